//--- baf_pkg.sv
// constants, register map and shared functions of the advertising telegram framer
// assumes a 100 MHz system clock and outside sources for payload, prand and hash
package baf_pkg;
  // timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned T_BIT_NS       = 1000;
  localparam int unsigned BIT_CYC        = (T_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_EVT_LONG_MS  = 20;
  localparam int unsigned T_EVT_SHORT_MS = 10;
  localparam int unsigned T_CH_GAP_US    = 150;
  localparam int unsigned EVT_LONG_CYC   = T_EVT_LONG_MS * CLK_MHZ * 1000;
  localparam int unsigned EVT_SHORT_CYC  = T_EVT_SHORT_MS * CLK_MHZ * 1000;
  localparam int unsigned CH_GAP_CYC     = T_CH_GAP_US * CLK_MHZ;
  // frame fields
  localparam logic [7:0]  PREAMBLE  = 8'haa;
  localparam logic [31:0] ACC_ADDR  = 32'h8e89bed6;
  localparam logic [7:0]  LEN_DATA  = 8'h13;
  localparam logic [7:0]  LEN_COMM  = 8'h24;
  localparam logic        RX_ADD    = 1'b0;
  localparam logic        TX_ADD    = 1'b1;
  localparam logic        CH_SEL    = 1'b0;
  localparam logic        HDR_RFU   = 1'b0;
  localparam logic [3:0]  PDU_TYPE  = 4'h2;
  localparam logic [15:0] HDR_DATA  = 16'h1342;
  localparam logic [15:0] HDR_COMM  = 16'h2442;
  localparam logic [4:0]  PLEN_DATA = 5'h0d;
  localparam logic [4:0]  PLEN_COMM = 5'h1e;
  // byte offsets inside the frame
  localparam logic [5:0]  OFS_ACC   = 6'h01;
  localparam logic [5:0]  OFS_HDR   = 6'h05;
  localparam logic [5:0]  OFS_ADR   = 6'h07;
  localparam logic [5:0]  OFS_PAY   = 6'h0d;
  localparam logic [5:0]  CRC_BYTES = 6'h03;
  // checksum and whitening
  localparam logic [23:0] CRC_INIT  = 24'h555555;
  localparam logic [23:0] CRC_POLY  = 24'h00065b;
  localparam logic [6:0]  WHT_RST   = 7'h01;
  // source address
  localparam logic [1:0]  TAG_STATIC  = 2'b11;
  localparam logic [1:0]  TAG_RPA     = 2'b01;
  localparam logic [15:0] DEV_TYPE_ID = 16'hc5a3; // arbitrary value
  localparam logic [3:0]  PROD_NIB    = 4'h9;     // arbitrary value
  localparam logic [27:0] RST_UID     = 28'h0000abc;
  // channels
  localparam int unsigned RF_BASE_MHZ  = 2400;
  localparam int unsigned CUST_F0_MHZ  = 2403;
  localparam logic [6:0]  CUST_CH_FIRST = 7'h28;
  localparam logic [6:0]  RST_CH0 = 7'h25;
  localparam logic [6:0]  RST_CH1 = 7'h26;
  localparam logic [6:0]  RST_CH2 = 7'h27;
  // register map
  localparam logic [3:0]  REG_CTRL = 4'h0;
  localparam logic [3:0]  REG_CHAN = 4'h1;
  localparam logic [3:0]  REG_UID  = 4'h2;
  localparam logic [3:0]  REG_EVTS = 4'h3;
  localparam logic [3:0]  REG_STAT = 4'h4;
  localparam int unsigned CB_SHORT = 0;
  localparam int unsigned CB_RPA   = 1;
  localparam int unsigned CB_KEY   = 2;
  localparam int unsigned CB_REQ   = 3;
  localparam int unsigned CH1_POS  = 8;
  localparam int unsigned CH2_POS  = 16;
  localparam logic [3:0]  RST_EVTS = 4'h3;
  localparam logic [3:0]  MIN_EVTS = 4'h2;

  // whitening seed for a channel index
  function automatic logic [5:0] wht_seed(input logic [6:0] ch);
    if (ch < CUST_CH_FIRST)
      return ch[5:0];
    return 6'((CUST_F0_MHZ - RF_BASE_MHZ) + 2 * (int'(ch) - int'(CUST_CH_FIRST)));
  endfunction : wht_seed

  // advertising header word for a telegram type
  function automatic logic [15:0] adv_hdr(input logic comm);
    return {comm ? LEN_COMM : LEN_DATA, RX_ADD, TX_ADD, CH_SEL, HDR_RFU, PDU_TYPE};
  endfunction : adv_hdr
endpackage : baf_pkg

//--- baf_whiten.sv
// data whitening lfsr of the advertising framer
// assumes the framer loads it once per frame and steps it once per whitened bit
`timescale 1ns/1ns
module baf_whiten import baf_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ld,
  input  wire logic [5:0] seed,
  input  wire logic       step,
  output logic            w_bit
);
  typedef struct packed {
    logic [6:0] lfsr;
  } baf_wht_t;

  baf_wht_t q;
  baf_wht_t d;
  logic     fb;

  // load seed reversed with a one at position 0, then shift
  always_comb
  begin
    d  = q;
    fb = q.lfsr[6];
    if (ld)
      d.lfsr = {seed[0], seed[1], seed[2], seed[3], seed[4], seed[5], 1'b1};
    else if (step)
      d.lfsr = {q.lfsr[5:4], q.lfsr[3] ^ fb, q.lfsr[2:0], fb};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '{lfsr: WHT_RST};
    else
      q <= d;
  end

  assign w_bit = q.lfsr[6];

  property p_wht_load;
    @(posedge clk) disable iff (rst)
    ld |=> q.lfsr[0] && q.lfsr[6] == $past(seed[0]) && q.lfsr[1] == $past(seed[5]);
  endproperty
  a_wht_load: assert property (p_wht_load) else $error("whitener seed not loaded");
endmodule : baf_whiten

//--- baf_crc24.sv
// serial 24 bit advertising checksum of the framer
// assumes one load per frame and one step per unwhitened bit in the covered span
`timescale 1ns/1ns
module baf_crc24 import baf_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ld,
  input  wire logic        step,
  input  wire logic        din,
  output logic      [23:0] crc
);
  typedef struct packed {
    logic [23:0] sr;
  } baf_crc_t;

  baf_crc_t q;
  baf_crc_t d;
  logic     fb;

  // galois shift with the advertising polynomial
  always_comb
  begin
    d  = q;
    fb = din ^ q.sr[23];
    if (ld)
      d.sr = CRC_INIT;
    else if (step)
      d.sr = {q.sr[22:0], 1'b0} ^ (fb ? CRC_POLY : 24'h000000);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '{sr: CRC_INIT};
    else
      q <= d;
  end

  assign crc = q.sr;

  property p_crc_init;
    @(posedge clk) disable iff (rst)
    ld ##1 !ld && !step |=> crc == CRC_INIT;
  endproperty
  a_crc_init: assert property (p_crc_init) else $error("crc not held at init value");
endmodule : baf_crc24

//--- baf_frame_tx.sv
// advertising telegram framer: event sequencer, frame assembly, bit serialiser
// assumes payload bytes, prand and hash are supplied by outside logic, held stable
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module baf_frame_tx import baf_pkg::*; #(
  parameter int unsigned EVT_LONG  = EVT_LONG_CYC,
  parameter int unsigned EVT_SHORT = EVT_SHORT_CYC,
  parameter int unsigned CH_GAP    = CH_GAP_CYC,
  parameter int unsigned BIT_PER   = BIT_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output logic      [31:0] RD_DATA,
  input  wire logic        ACTUATE,
  input  wire logic        LEARN_BUTTON,
  input  wire logic [23:0] PRAND_IN,
  input  wire logic [23:0] HASH_IN,
  input  wire logic [7:0]  PAY_BYTE,
  output logic      [4:0]  PAY_IDX,
  output logic             KEY_SEL_USER,
  output logic             TELE_COMM,
  output logic             TX_ACTIVE,
  output logic             TX_BIT,
  output logic             TX_STB,
  output logic      [6:0]  TX_CHAN,
  output logic             TELE_DONE
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SEND = 2'b01,
    S_GAP  = 2'b11,
    S_WAIT = 2'b10
  } baf_st_t;

  typedef struct packed {
    baf_st_t         st;
    logic [23:0]     tmr;
    logic [2:0]      bitn;
    logic [5:0]      byte_idx;
    logic [4:0]      pay_idx;
    logic [1:0]      chan_i;
    logic [3:0]      evt_i;
    logic            comm;
    logic [47:0]     src;
    logic            tx_bit;
    logic            tx_stb;
    logic            done;
    logic            short_gap;
    logic            rpa_en;
    logic            key_user;
    logic            comm_req;
    logic [2:0][6:0] ch;
    logic [27:0]     uid;
    logic [3:0]      nevt;
    logic [31:0]     rd_data;
  } baf_main_t;

  localparam baf_main_t Q_RST = '{
    st: S_IDLE, tmr: 24'h000000, bitn: 3'h0, byte_idx: 6'h00, pay_idx: 5'h00,
    chan_i: 2'h0, evt_i: 4'h0, comm: 1'b0, src: 48'h000000000000,
    tx_bit: 1'b0, tx_stb: 1'b0, done: 1'b0, short_gap: 1'b0, rpa_en: 1'b0,
    key_user: 1'b0, comm_req: 1'b0, ch: {RST_CH2, RST_CH1, RST_CH0},
    uid: RST_UID, nevt: RST_EVTS, rd_data: 32'h00000000
  };

  baf_main_t   q;
  baf_main_t   d;
  logic        ld;
  logic [5:0]  ld_seed;
  logic        step_w;
  logic        step_c;
  logic        w_bit;
  logic [23:0] crc;
  logic [4:0]  plen;
  logic [5:0]  crc_ofs;
  logic [5:0]  last_ofs;
  logic [3:0]  nevt_eff;
  logic [7:0]  cur_byte;
  logic [15:0] hdr;
  logic [4:0]  crc_bit;
  logic        dbit;
  logic        obit;
  logic [47:0] src_new;

  // frame geometry follows the telegram type
  always_comb
  begin
    plen     = q.comm ? PLEN_COMM : PLEN_DATA;
    crc_ofs  = OFS_PAY + {1'b0, plen};
    last_ofs = crc_ofs + CRC_BYTES - 6'h01;
    nevt_eff = (q.nevt < MIN_EVTS) ? MIN_EVTS : q.nevt;
    hdr      = adv_hdr(q.comm);
  end

  // source address chosen at telegram start
  always_comb
  begin
    if (q.rpa_en)
      src_new = {TAG_RPA, PRAND_IN[21:0], HASH_IN};
    else
      src_new = {TAG_STATIC, DEV_TYPE_ID[13:0], PROD_NIB, q.uid};
  end

  // byte under the serialiser, lsb first, checksum bits msb first
  always_comb
  begin
    cur_byte = 8'h00;
    if (q.byte_idx < OFS_ACC)
      cur_byte = PREAMBLE;
    else if (q.byte_idx < OFS_HDR)
      cur_byte = ACC_ADDR[8 * (q.byte_idx - OFS_ACC) +: 8];
    else if (q.byte_idx < OFS_ADR)
      cur_byte = hdr[8 * (q.byte_idx - OFS_HDR) +: 8];
    else if (q.byte_idx < OFS_PAY)
      cur_byte = q.src[8 * (q.byte_idx - OFS_ADR) +: 8];
    else if (q.byte_idx < crc_ofs)
      cur_byte = PAY_BYTE;
    crc_bit = 5'(8 * (q.byte_idx - crc_ofs)) + {2'b00, q.bitn};
    if (q.byte_idx >= crc_ofs)
      dbit = crc[5'h17 - crc_bit];
    else
      dbit = cur_byte[q.bitn];
    obit = (q.byte_idx >= OFS_HDR) ? (dbit ^ w_bit) : dbit;
  end

  // registers, sequencer and serialiser
  always_comb
  begin
    d         = q;
    d.tx_stb  = 1'b0;
    d.done    = 1'b0;
    d.rd_data = 32'h00000000;
    ld        = 1'b0;
    ld_seed   = wht_seed(q.ch[0]);
    step_w    = 1'b0;
    step_c    = 1'b0;
    // register reads, data valid in the following cycle only
    if (RD_EN)
    begin
      unique case (ADDR)
        REG_CTRL: d.rd_data = {28'h0000000, q.comm_req, q.key_user, q.rpa_en, q.short_gap};
        REG_CHAN: d.rd_data = {9'h000, q.ch[2], 1'b0, q.ch[1], 1'b0, q.ch[0]};
        REG_UID:  d.rd_data = {PROD_NIB, q.uid};
        REG_EVTS: d.rd_data = {28'h0000000, q.nevt};
        REG_STAT: d.rd_data = {17'h00000, q.byte_idx, q.evt_i, q.chan_i, q.comm, q.st};
        default:  d.rd_data = 32'h00000000;
      endcase
    end
    // register writes; status is read only
    if (WR_EN)
    begin
      unique case (ADDR)
        REG_CTRL:
        begin
          d.short_gap = WR_DATA[CB_SHORT];
          d.rpa_en    = WR_DATA[CB_RPA];
          d.key_user  = WR_DATA[CB_KEY];
        end
        REG_CHAN:
        begin
          d.ch[0] = WR_DATA[6:0];
          d.ch[1] = WR_DATA[CH1_POS +: 7];
          d.ch[2] = WR_DATA[CH2_POS +: 7];
        end
        REG_UID:  d.uid  = WR_DATA[27:0];
        REG_EVTS: d.nevt = WR_DATA[3:0];
        default:  d.nevt = q.nevt;
      endcase
    end
    unique case (q.st)
      S_IDLE:
      begin
        if (ACTUATE)
        begin
          d.comm     = LEARN_BUTTON | q.comm_req;
          d.comm_req = 1'b0;
          d.src      = src_new;
          d.evt_i    = 4'h0;
          d.chan_i   = 2'h0;
          d.byte_idx = 6'h00;
          d.bitn     = 3'h0;
          d.tmr      = 24'h000000;
          d.st       = S_SEND;
          ld         = 1'b1;
        end
      end
      S_SEND:
      begin
        if (q.tmr != 24'h000000)
          d.tmr = q.tmr - 24'h000001;
        else
        begin
          d.tx_bit = obit;
          d.tx_stb = 1'b1;
          d.tmr    = 24'(BIT_PER - 1);
          d.bitn   = q.bitn + 3'h1;
          step_w   = (q.byte_idx >= OFS_HDR);
          step_c   = (q.byte_idx >= OFS_HDR) && (q.byte_idx < crc_ofs);
          if (q.bitn == 3'h7)
            d.byte_idx = q.byte_idx + 6'h01;
          if (q.bitn == 3'h7 && q.byte_idx == last_ofs)
          begin
            d.byte_idx = 6'h00;
            if (q.chan_i != 2'h2)
            begin
              d.st  = S_GAP;
              d.tmr = 24'(CH_GAP - 1);
            end
            else if (q.evt_i + 4'h1 < nevt_eff)
            begin
              d.st  = S_WAIT;
              d.tmr = q.short_gap ? 24'(EVT_SHORT - 1) : 24'(EVT_LONG - 1);
            end
            else
            begin
              d.st   = S_IDLE;
              d.done = 1'b1;
            end
          end
        end
      end
      S_GAP:
      begin
        d.tmr = q.tmr - 24'h000001;
        if (q.tmr == 24'h000000)
        begin
          d.chan_i = q.chan_i + 2'h1;
          d.tmr    = 24'h000000;
          d.st     = S_SEND;
          ld       = 1'b1;
          ld_seed  = wht_seed(q.ch[q.chan_i + 2'h1]);
        end
      end
      S_WAIT:
      begin
        d.tmr = q.tmr - 24'h000001;
        if (q.tmr == 24'h000000)
        begin
          d.evt_i  = q.evt_i + 4'h1;
          d.chan_i = 2'h0;
          d.tmr    = 24'h000000;
          d.st     = S_SEND;
          ld       = 1'b1;
        end
      end
    endcase
    d.pay_idx = 5'(d.byte_idx - OFS_PAY);
    // pending commissioning request, a new request wins over the clear
    if (WR_EN && ADDR == REG_CTRL && WR_DATA[CB_REQ])
      d.comm_req = 1'b1;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      q <= Q_RST;
    else
      q <= d;
  end

  baf_whiten u_wht (
    .clk   (CLK_SYS),
    .rst   (RESET),
    .ld    (ld),
    .seed  (ld_seed),
    .step  (step_w),
    .w_bit (w_bit)
  );

  baf_crc24 u_crc (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .ld   (ld),
    .step (step_c),
    .din  (dbit),
    .crc  (crc)
  );

  // outputs
  assign RD_DATA      = q.rd_data;
  assign PAY_IDX      = q.pay_idx;
  assign KEY_SEL_USER = q.key_user;
  assign TELE_COMM    = q.comm;
  assign TX_ACTIVE    = (q.st == S_SEND);
  assign TX_BIT       = q.tx_bit;
  assign TX_STB       = q.tx_stb;
  assign TX_CHAN      = q.ch[q.chan_i];
  assign TELE_DONE    = q.done;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  property p_pre;
    q.st == S_SEND && q.tmr == 24'h000000 && q.byte_idx == 6'h00 |=> TX_BIT == $past(q.bitn[0]);
  endproperty
  a_pre: assert property (p_pre) else $error("preamble bit wrong");

  property p_acc_lsb;
    q.st == S_SEND && q.byte_idx == OFS_ACC |-> cur_byte == 8'hd6;
  endproperty
  a_acc_lsb: assert property (p_acc_lsb) else $error("access address not lsb first");

  property p_hdr;
    q.st == S_SEND |-> hdr == (q.comm ? HDR_COMM : HDR_DATA);
  endproperty
  a_hdr: assert property (p_hdr) else $error("header word wrong");

  property p_static;
    q.st == S_IDLE && ACTUATE && !q.rpa_en |=> q.src[47:46] == 2'b11;
  endproperty
  a_static: assert property (p_static) else $error("static address tag wrong");

  property p_rpa;
    q.st == S_IDLE && ACTUATE && q.rpa_en |=> q.src[47:46] == 2'b01 && q.src[23:0] == $past(HASH_IN);
  endproperty
  a_rpa: assert property (p_rpa) else $error("private address wrong");

  property p_same;
    q.st != S_IDLE && $past(q.st) != S_IDLE |-> $stable(q.src) && $stable(q.comm);
  endproperty
  a_same: assert property (p_same) else $error("telegram changed between events");

  property p_min2;
    TELE_DONE |-> q.evt_i >= 4'h1 && q.chan_i == 2'h2;
  endproperty
  a_min2: assert property (p_min2) else $error("fewer than two events sent");

  property p_gap;
    q.st == S_SEND ##1 q.st == S_WAIT |-> q.tmr == (q.short_gap ? 24'(EVT_SHORT - 1) : 24'(EVT_LONG - 1));
  endproperty
  a_gap: assert property (p_gap) else $error("event spacing wrong");

  property p_seed;
    ld |-> ld_seed == wht_seed(q.st == S_GAP ? q.ch[q.chan_i + 2'h1] : q.ch[0]);
  endproperty
  a_seed: assert property (p_seed) else $error("whitening seed wrong");
endmodule : baf_frame_tx

//--- baf_rx_model.sv
// receiver model: de-whitens the serial frame, rebuilds bytes and checks the checksum
// assumes one TX_STB pulse per bit and TX_ACTIVE low between frames
`timescale 1ns/1ns
module baf_rx_model import baf_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       active,
  input  wire logic       stb,
  input  wire logic       bit_in,
  input  wire logic [6:0] chan,
  output logic            byte_stb,
  output logic      [7:0] byte_val,
  output logic            frm_end,
  output logic            crc_ok,
  output logic      [6:0] frm_chan
);
  int          n = 0;
  logic        b;
  logic  [6:0] s;
  logic  [6:0] lfsr;
  logic [23:0] crc;
  logic [23:0] crc_rx;
  logic  [7:0] sh;
  logic  [7:0] len;

  // bit receiver, one frame at a time
  always @(posedge clk)
  begin
    byte_stb <= 1'b0;
    frm_end  <= 1'b0;
    if (rst)
      n = 0;
    else if (stb)
    begin
      b = bit_in;
      if (n == 0)
      begin
        s = (chan < 7'd40) ? chan : 7'(2 * int'(chan) - 77);
        lfsr = {s[0], s[1], s[2], s[3], s[4], s[5], 1'b1};
        crc = 24'h555555;
        len = 8'hff;
        frm_chan <= chan;
      end
      // whitening and checksum start at the header
      if (n >= 40)
      begin
        b = b ^ lfsr[6];
        lfsr = {lfsr[5:4], lfsr[3] ^ lfsr[6], lfsr[2:0], lfsr[6]};
        if (n < (7 + len) * 8)
          crc = {crc[22:0], 1'b0} ^ ((crc[23] ^ b) ? 24'h00065b : 24'h000000);
        else
          crc_rx = {crc_rx[22:0], b};
      end
      sh = {b, sh[7:1]};
      n++;
      if (n % 8 == 0 && n <= (7 + len) * 8)
      begin
        byte_stb <= 1'b1;
        byte_val <= sh;
      end
      if (n == 56)
        len = sh;
    end
    else if (!active && n != 0)
    begin
      frm_end <= 1'b1;
      crc_ok  <= (crc === crc_rx);
      n = 0;
    end
  end
endmodule : baf_rx_model

//--- baf_frame_tx_tb_top.sv
// self-checking bench of the advertising telegram framer
// assumes baf_pkg, the framer files and baf_rx_model are compiled before it
`timescale 1ns/1ns
module baf_frame_tx_tb_top import baf_pkg::*; ;
  localparam int unsigned CHG = 20;
  localparam int unsigned EVL = 200;
  localparam int unsigned EVS = 100;
  logic        clk_sys;
  logic        rst = 1'b1;
  logic  [3:0] addr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        wen = 1'b0;
  logic        ren = 1'b0;
  logic [31:0] rdat;
  logic        act = 1'b0;
  logic        learn = 1'b0;
  logic [23:0] prand = 24'h0;
  logic [23:0] hash = 24'h0;
  logic  [7:0] pay_byte;
  logic  [4:0] pay_idx;
  logic        key_user, comm, tx_act, tx_bit, tx_stb, done;
  logic  [6:0] tx_chan;
  logic        rx_stb, rx_end, rx_crc_ok, rd_p = 1'b0, run = 1'b0;
  logic  [7:0] rx_byte;
  logic  [6:0] rx_chan;
  logic  [7:0] pay_tab [32];
  logic  [6:0] chs [3];
  logic [27:0] uid_v = 28'habc;
  logic  [7:0] bq [$];
  logic  [6:0] fq [$];
  logic [31:0] rq [$];
  int          eg [$];
  int          fails = 0, checked = 0, cyc = 0, g = 0;

  baf_frame_tx #(.EVT_LONG(EVL), .EVT_SHORT(EVS), .CH_GAP(CHG), .BIT_PER(4)) dut (
    .CLK_SYS(clk_sys), .RESET(rst), .ADDR(addr), .WR_DATA(wdat), .WR_EN(wen),
    .RD_EN(ren), .RD_DATA(rdat), .ACTUATE(act), .LEARN_BUTTON(learn),
    .PRAND_IN(prand), .HASH_IN(hash), .PAY_BYTE(pay_byte), .PAY_IDX(pay_idx),
    .KEY_SEL_USER(key_user), .TELE_COMM(comm), .TX_ACTIVE(tx_act), .TX_BIT(tx_bit),
    .TX_STB(tx_stb), .TX_CHAN(tx_chan), .TELE_DONE(done));
  baf_rx_model rx (
    .clk(clk_sys), .rst(rst), .active(tx_act), .stb(tx_stb), .bit_in(tx_bit),
    .chan(tx_chan), .byte_stb(rx_stb), .byte_val(rx_byte), .frm_end(rx_end),
    .crc_ok(rx_crc_ok), .frm_chan(rx_chan));

  // payload source answers the index the framer shows
  assign pay_byte = pay_tab[pay_idx];

  task automatic bad(input string m);
    fails++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : bad
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) bad($sformatf("value %h, expected %h", got, e));
  endtask : cmp_reg
  task automatic cmp_byte(input logic [7:0] got);
    logic [7:0] e;
    checked++;
    e = (bq.size() == 0) ? ~got : bq.pop_front();
    if (got !== e) bad($sformatf("byte %h, expected %h", got, e));
  endtask : cmp_byte
  task automatic cmp_frm(input logic ok, input logic [6:0] ch);
    logic [6:0] e;
    checked++;
    e = (fq.size() == 0) ? ~ch : fq.pop_front();
    if (ok !== 1'b1 || ch !== e) bad($sformatf("frame chan %0d crc %b", ch, ok));
  endtask : cmp_frm
  task automatic cmp_gap(input int got);
    int e;
    checked++;
    e = (eg.size() == 0) ? -100 : eg.pop_front();
    if (got < e - 4 || got > e + 4) bad($sformatf("gap %0d, expected %0d", got, e));
  endtask : cmp_gap
  task automatic finish_test();
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // register bus master, one strobe per call
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdat <= d;
    wen  <= 1'b1;
    @(posedge clk_sys);
    wen  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    ren  <= 1'b1;
    rq.push_back(e);
    @(posedge clk_sys);
    ren  <= 1'b0;
  endtask : rd
  task automatic pulse();
    @(posedge clk_sys);
    act <= 1'b1;
    @(posedge clk_sys);
    act <= 1'b0;
  endtask : pulse

  // new random content, expected frames noted, then one actuation
  task automatic tele(input logic cm, input logic pv, input int nf, input int gp);
    logic [103:0] hd;
    @(posedge clk_sys);
    prand <= $urandom;
    hash  <= $urandom;
    foreach (pay_tab[i]) pay_tab[i] <= $urandom;
    @(posedge clk_sys);
    hd[39:0]  = {32'h8e89bed6, 8'haa};
    hd[55:40] = cm ? 16'h2442 : 16'h1342;
    hd[103:56] = pv ? {2'b01, prand[21:0], hash}
                    : {2'b11, DEV_TYPE_ID[13:0], PROD_NIB, uid_v};
    for (int f = 0; f < nf; f++)
    begin
      fq.push_back(chs[f % 3]);
      if (f > 0) eg.push_back((f % 3 == 0) ? gp : CHG);
      for (int k = 0; k < 13; k++) bq.push_back(hd[8 * k +: 8]);
      for (int k = 0; k < (cm ? 30 : 13); k++) bq.push_back(pay_tab[k]);
    end
    pulse();
  endtask : tele

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // result watcher: reads, bytes, frames, idle gaps and the watchdog
  always @(posedge clk_sys)
  begin
    if (rd_p) cmp_reg(rdat, rq.pop_front());
    rd_p <= ren;
    if (rx_stb) cmp_byte(rx_byte);
    if (rx_end) cmp_frm(rx_crc_ok, rx_chan);
    if (rst || done) run <= 1'b0;
    else if (tx_act) run <= 1'b1;
    g <= (tx_act || !run) ? 0 : g + 1;
    if (tx_act && g > 0) cmp_gap(g);
    cyc++;
    if (cyc == 40000)
    begin
      bad("timeout");
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(32'hbbcbe226));
    foreach (pay_tab[i]) pay_tab[i] = 8'h00;
    chs = '{7'd37, 7'd38, 7'd39};
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_CHAN, 32'h00272625);
    rd(REG_UID, 32'h90000abc);
    rd(REG_EVTS, 32'h3);
    rd(4'hf, 32'h0);
    wr(4'hf, 32'hffffffff);
    wr(REG_UID, 32'h01234567);
    uid_v = 28'h1234567;
    rd(REG_UID, 32'h91234567);
    wr(REG_EVTS, 32'h1);
    // data telegram, default channels and spacing, extra actuation ignored
    tele(1'b0, 1'b0, 6, EVL);
    repeat (3000) @(posedge clk_sys);
    pulse();
    @(posedge clk_sys iff done);
    cmp_reg({30'h0, key_user, comm}, 32'h0);
    // commissioning by request, private address, user key, custom channels
    chs = '{7'd40, 7'd70, 7'd12};
    wr(REG_CHAN, 32'h000c4628);
    wr(REG_CTRL, 32'hf);
    tele(1'b1, 1'b1, 6, EVS);
    @(posedge clk_sys iff done);
    cmp_reg({30'h0, key_user, comm}, 32'h3);
    rd(REG_CTRL, 32'h7);
    // learn button commissions, reset cuts the telegram after one frame
    learn <= 1'b1;
    wr(REG_CTRL, 32'h0);
    tele(1'b1, 1'b0, 1, EVL);
    @(posedge clk_sys iff rx_end);
    cmp_reg({30'h0, key_user, comm}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    cmp_reg({24'h0, tx_act, tx_chan}, 32'h25);
    repeat (3) @(posedge clk_sys);
    cmp_reg(bq.size() + fq.size() + eg.size() + rq.size(), 32'h0);
    finish_test();
  end
endmodule : baf_frame_tx_tb_top
